// File: design/jcc_pkg.sv
// constants, register layouts and codes of the jitter cleaner config bank
package jcc_pkg;
	// sampling clock and signal-loss timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int LOS_STEP_NS   = 1600;
	localparam int LOS_STEP_CYC  =
		(LOS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [5:0] FRAME_BITS = 6'h20;

	// register indexes; byte address is four times the index
	localparam logic [4:0] IDX_CFG0     = 5'h00;
	localparam logic [4:0] IDX_CFG1     = 5'h01;
	localparam logic [4:0] IDX_CFG2     = 5'h02;
	localparam logic [4:0] IDX_STATUS   = 5'h10;
	localparam logic [4:0] IDX_IRQ_STAT = 5'h11;
	localparam logic [4:0] IDX_IRQ_EN   = 5'h12;
	localparam logic [4:0] IDX_IRQ_CLR  = 5'h13;
	localparam logic [4:0] IDX_LOCK     = 5'h1F;

	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// interrupt status bit positions
	localparam int IRQ_LOS_A  = 0;
	localparam int IRQ_LOS_B  = 1;
	localparam int IRQ_SWITCH = 2;
	localparam int IRQ_REJECT = 3;
	localparam int IRQ_W      = 4;

	// topology, reference mode, pin type and pin signal codes
	localparam logic [2:0] TOPO_DUAL      = 3'h0;
	localparam logic [2:0] TOPO_DUAL_ZD   = 3'h1;
	localparam logic [2:0] TOPO_SINGLE    = 3'h2;
	localparam logic [2:0] TOPO_SINGLE_ZD = 3'h3;
	localparam logic [2:0] TOPO_DIST      = 3'h4;
	localparam logic [1:0] REF_MANUAL_A   = 2'h0;
	localparam logic [1:0] REF_MANUAL_B   = 2'h1;
	localparam logic [1:0] REF_AUTO       = 2'h2;
	localparam logic [1:0] PIN_INPUT      = 2'h0;
	localparam logic [1:0] PIN_PUSH_PULL  = 2'h1;
	localparam logic [1:0] PIN_OPEN_DRAIN = 2'h2;
	localparam logic [2:0] SIG_LOW        = 3'h0;
	localparam logic [2:0] SIG_PLL_LOCK   = 3'h1;
	localparam logic [2:0] SIG_LOS_A      = 3'h2;
	localparam logic [2:0] SIG_LOS_B      = 3'h3;
	localparam logic [2:0] SIG_REF_B      = 3'h4;
	localparam logic [2:0] SIG_IRQ        = 3'h5;
	localparam logic [2:0] SIG_HIGH       = 3'h6;

	// register layouts, lsb last
	typedef struct packed {
		logic [19:0] rsvd;
		logic        distributionSourceSelect;
		logic [1:0]  oscInputFrequencyRange;
		logic [2:0]  feedbackSelect;
		logic        oscInputBufferPowerdown;
		logic [2:0]  topology;
		logic        powerdown;
		logic        swReset;
	} cfg0_t;
	typedef struct packed {
		logic [23:0] rsvd;
		logic [2:0]  signalLossTimeout;
		logic        signalLossDetectEnable;
		logic        refInputBAutoEnable;
		logic        refInputAAutoEnable;
		logic [1:0]  referenceSelectMode;
	} cfg1_t;
	typedef struct packed {
		logic [23:0] rsvd;
		logic [2:0]  holdoverPinSignalSelect;
		logic [1:0]  lockPinIoType;
		logic [2:0]  lockPinSignalSelect;
	} cfg2_t;

	// values after reset
	localparam logic [31:0] CFG0_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG1_RESET = 32'h0000_0004;
	localparam logic [31:0] CFG2_RESET = 32'h0000_0009;
endpackage : jcc_pkg

// File: design/jitter_cleaner_config_controls.sv
// config bank: serial and axi4-lite writes, signal-loss, ref select, pins
//
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps

// What this block does
// (RULE_01) reset bit restores all config defaults
// (RULE_02) host clears reset bit afterwards
// (RULE_03) powerdown bit powers whole device down
// (RULE_04) topology field selects active loops
// (RULE_05) bit powers down oscillator input buffer
// (RULE_06) feedback field picks zero-delay feedback source
// (RULE_07) host sets oscillator frequency range correctly
// (RULE_08) divided source only in internal oscillator topologies
// (RULE_09) lock set blocks writes to registers 0-30; code blocks only registers 0-2, irq enable and clear stay writable
// (RULE_10) mode field chooses reference selection method
// (RULE_11) auto switching never picks disabled inputs
// (RULE_12) enable bit activates signal-loss monitoring
// (RULE_13) timeout field sets inactivity before loss
// (RULE_14) selectors choose lock and holdover pin signals
// (RULE_15) type field sets lock pin direction
// (RULE_16) only complete latched frames change registers
module jitter_cleaner_config_controls (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// axi4-lite slave
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	// serial programming pins
	input  wire logic        serClk,
	input  wire logic        serData,
	input  wire logic        serLatch,
	// reference inputs and loop status
	input  wire logic        referenceInputA,
	input  wire logic        referenceInputB,
	input  wire logic        pllLocked,
	// configuration outputs
	output logic             deviceDown,
	output logic             pll1Active,
	output logic             pll2Active,
	output logic             zeroDelayActive,
	output logic             oscInputBufferDown,
	output logic [2:0]       feedbackSelect,
	output logic             distUsesDivider,
	output logic [1:0]       oscInputFrequencyRange,
	output logic             refSelectB,
	output logic [1:0]       signalLoss,
	// status pins
	input  wire logic        lockStatusPinIn,
	output logic             lockStatusPinOut,
	output logic             lockStatusPinOe,
	output logic             holdoverPinOut,
	// interrupt
	output logic             irq
);
	import jcc_pkg::*;

	typedef struct packed {
		cfg0_t             cfg0;
		cfg1_t             cfg1;
		cfg2_t             cfg2;
		logic              progLock;
		logic [2:0]        serClkS;
		logic [1:0]        serDataS;
		logic [2:0]        serLatchS;
		logic [1:0][2:0]   refS;
		logic [1:0]        lockInS;
		logic [31:0]       shift;
		logic [5:0]        bitCnt;
		logic [1:0][7:0]   losCnt;
		logic [1:0]        los;
		logic              refSelB;
		logic [IRQ_W-1:0]  irqStat;
		logic [IRQ_W-1:0]  irqEn;
		logic              awHave;
		logic              awBad;
		logic [4:0]        awIdx;
		logic              wHave;
		logic [31:0]       wData;
		logic [3:0]        wStrb;
		logic              bValid;
		logic [1:0]        bResp;
		logic              rValid;
		logic [31:0]       rData;
		logic [1:0]        rResp;
		logic [10:0]       outs;
		logic [2:0]        fbSel;
		logic [1:0]        freqRange;
		logic              hoPin;
	} state_t;

	state_t q;
	state_t d;

	// decode shared by read path and write merge
	function automatic logic isMapped(input logic [4:0] idx);
		isMapped = idx inside {IDX_CFG0, IDX_CFG1, IDX_CFG2, IDX_STATUS,
			IDX_IRQ_STAT, IDX_IRQ_EN, IDX_IRQ_CLR, IDX_LOCK};
	endfunction : isMapped

	function automatic logic [31:0] regVal(input state_t s,
		input logic [4:0] idx);
		unique case (idx)
			IDX_CFG0:     regVal = s.cfg0;
			IDX_CFG1:     regVal = s.cfg1;
			IDX_CFG2:     regVal = s.cfg2;
			IDX_LOCK:     regVal = {31'h0000_0000, s.progLock};
			IDX_STATUS:   regVal = {28'h000_0000, s.lockInS[1], s.refSelB,
				s.los};
			IDX_IRQ_STAT: regVal = {28'h000_0000, s.irqStat};
			IDX_IRQ_EN:   regVal = {28'h000_0000, s.irqEn};
			default:      regVal = 32'h0000_0000; // clear reads zero
		endcase
	endfunction : regVal

	// pin signal mux, used for lock and holdover pins
	function automatic logic pinSig(input state_t s, input logic [2:0] sel);
		unique case (sel)
			SIG_PLL_LOCK: pinSig = pllLocked;
			SIG_LOS_A:    pinSig = s.los[0];
			SIG_LOS_B:    pinSig = s.los[1];
			SIG_REF_B:    pinSig = s.refSelB;
			SIG_IRQ:      pinSig = |(s.irqStat & s.irqEn);
			SIG_HIGH:     pinSig = 1'b1;
			default:      pinSig = 1'b0;
		endcase
	endfunction : pinSig

	// handshake outputs straight from state
	assign awready = ~q.awHave;
	assign wready  = ~q.wHave;
	assign bvalid  = q.bValid;
	assign bresp   = q.bResp;
	assign arready = ~q.rValid;
	assign rvalid  = q.rValid;
	assign rdata   = q.rData;
	assign rresp   = q.rResp;
	assign irq     = |(q.irqStat & q.irqEn);

	// registered data outputs
	assign {deviceDown, pll1Active, pll2Active, zeroDelayActive,
		oscInputBufferDown, distUsesDivider, refSelectB, signalLoss,
		lockStatusPinOut, lockStatusPinOe} = q.outs;
	assign holdoverPinOut         = q.hoPin; // RULE_14
	assign feedbackSelect         = q.fbSel;
	assign oscInputFrequencyRange = q.freqRange; // RULE_07

	// next-state logic for the whole bank
	always_comb begin
		logic        serEdge;
		logic        latchRise;
		logic        doWrite;
		logic        fromSer;
		logic [4:0]  wIdx;
		logic [31:0] wVal;
		logic [31:0] merged;
		logic [3:0]  strb;
		logic [31:0] clrMask;
		logic [IRQ_W-1:0] ev;
		logic [7:0]  losLimit;
		logic [1:0]  enMask;
		logic        cur;
		logic        curOk;
		logic        othOk;
		logic [3:0]  topo;
		logic        sig;
		d         = q;
		doWrite   = 1'b0;
		fromSer   = 1'b0;
		wIdx      = q.awIdx;
		wVal      = q.wData;
		strb      = q.wStrb;
		merged    = 32'h0000_0000;
		clrMask   = 32'h0000_0000;
		ev        = '0;
		topo      = 4'h0;
		// two-stage synchronisers, third stage only for edges
		d.serClkS   = {q.serClkS[1:0], serClk};
		d.serDataS  = {q.serDataS[0], serData};
		d.serLatchS = {q.serLatchS[1:0], serLatch};
		d.refS[0]   = {q.refS[0][1:0], referenceInputA};
		d.refS[1]   = {q.refS[1][1:0], referenceInputB};
		d.lockInS   = {q.lockInS[0], lockStatusPinIn};
		serEdge   = q.serClkS[1] & ~q.serClkS[2];
		latchRise = q.serLatchS[1] & ~q.serLatchS[2];
		// serial shifter, msb first; count saturates on overlong frames
		if (serEdge) begin
			d.shift = {q.shift[30:0], q.serDataS[1]};
			if (q.bitCnt != 6'h3F)
				d.bitCnt = q.bitCnt + 6'h01;
		end
		if (latchRise) begin
			d.bitCnt = 6'h00;
			if (q.bitCnt == FRAME_BITS) begin // RULE_16
				doWrite = 1'b1;
				fromSer = 1'b1;
				wIdx    = q.shift[4:0];
				wVal    = {5'h00, q.shift[31:5]};
				strb    = 4'hF;
			end
		end
		// axi capture; address and data accepted in either order
		if (awvalid && !q.awHave) begin
			d.awHave = 1'b1;
			d.awIdx  = awaddr[6:2];
			d.awBad  = (|awaddr[31:7]) | ~isMapped(awaddr[6:2]);
		end
		if (wvalid && !q.wHave) begin
			d.wHave = 1'b1;
			d.wData = wdata;
			d.wStrb = wstrb;
		end
		if (q.bValid && bready)
			d.bValid = 1'b0;
		// serial frame wins the write port; the bus write waits a cycle
		if (!fromSer && q.awHave && q.wHave && !q.bValid) begin
			doWrite  = 1'b1;
			d.awHave = 1'b0;
			d.wHave  = 1'b0;
			d.bValid = 1'b1;
			d.bResp  = q.awBad ? RESP_SLVERR : RESP_OKAY;
		end
		// byte-lane merge into the current register value
		for (int b = 0; b < 4; b++)
			merged[b*8 +: 8] = strb[b] ? wVal[b*8 +: 8]
				: 8'(regVal(q, wIdx) >> (b*8));
		if (doWrite && (fromSer || !q.awBad)) begin
			unique case (wIdx)
				IDX_LOCK: d.progLock = merged[0];
				IDX_CFG0, IDX_CFG1, IDX_CFG2: begin
					if (q.progLock) begin
						ev[IRQ_REJECT] = 1'b1; // RULE_09
					end else if (wIdx == IDX_CFG0 && merged[0]) begin
						// every unlocked write with the bit set resets again
						d.cfg0     = CFG0_RESET | 32'h0000_0001; // RULE_01 RULE_02
						d.cfg1     = CFG1_RESET;
						d.cfg2     = CFG2_RESET;
						d.progLock = 1'b0;
					end else if (wIdx == IDX_CFG0) begin
						d.cfg0 = merged;
					end else if (wIdx == IDX_CFG1) begin
						d.cfg1 = merged;
					end else begin
						d.cfg2 = merged;
					end
				end
				// interrupt registers are bus-only; serial frames skip them
				IDX_IRQ_EN:  d.irqEn = fromSer ? q.irqEn : merged[IRQ_W-1:0]; // RULE_09
				IDX_IRQ_CLR: clrMask = fromSer ? 32'h0000_0000 : wVal;
				default: ;
			endcase
		end
		// axi read, one cycle after the address is taken
		if (q.rValid && rready)
			d.rValid = 1'b0;
		if (arvalid && !q.rValid) begin
			d.rValid = 1'b1;
			if ((|araddr[31:7]) || !isMapped(araddr[6:2])) begin
				d.rData = 32'h0000_0000;
				d.rResp = RESP_SLVERR;
			end else begin
				d.rData = regVal(q, araddr[6:2]);
				d.rResp = RESP_OKAY;
			end
		end
		// signal-loss counters, restarted by any input transition
		losLimit = 8'(({5'h00, q.cfg1.signalLossTimeout} + 8'h01)
			* 8'(LOS_STEP_CYC)); // RULE_13
		for (int i = 0; i < 2; i++) begin
			if (!q.cfg1.signalLossDetectEnable
				|| (q.refS[i][1] ^ q.refS[i][2])) begin // RULE_12
				d.losCnt[i] = 8'h00;
				d.los[i]    = 1'b0;
			end else if (q.losCnt[i] >= losLimit) begin
				d.los[i] = 1'b1; // RULE_13
			end else begin
				d.losCnt[i] = q.losCnt[i] + 8'h01;
			end
		end
		ev[IRQ_LOS_A] = d.los[0] & ~q.los[0];
		ev[IRQ_LOS_B] = d.los[1] & ~q.los[1];
		// reference selection; mode 3 holds the present choice
		enMask = {q.cfg1.refInputBAutoEnable, q.cfg1.refInputAAutoEnable};
		cur    = q.refSelB;
		curOk  = enMask[cur] & ~q.los[cur];
		othOk  = enMask[~cur] & ~q.los[~cur];
		unique case (q.cfg1.referenceSelectMode) // RULE_10
			REF_MANUAL_A: d.refSelB = 1'b0;
			REF_MANUAL_B: d.refSelB = 1'b1;
			REF_AUTO: begin
				if (!curOk && othOk)
					d.refSelB = ~cur; // RULE_11
			end
			default: ;
		endcase
		ev[IRQ_SWITCH] = d.refSelB ^ q.refSelB;
		// sticky status: a new event beats a same-cycle clear
		d.irqStat = (q.irqStat & ~clrMask[IRQ_W-1:0]) | ev;
		// topology decode {loop1, loop2, zero delay, internal oscillator}
		unique case (q.cfg0.topology) // RULE_04
			TOPO_DUAL:      topo = 4'b1101;
			TOPO_DUAL_ZD:   topo = 4'b1111;
			TOPO_SINGLE:    topo = 4'b0101;
			TOPO_SINGLE_ZD: topo = 4'b0111;
			default:        topo = 4'b0000; // distribution and unused codes
		endcase
		if (q.cfg0.powerdown)
			topo = 4'b0000; // RULE_03
		// lock pin drive by type; open drain pulls low only
		sig = pinSig(q, q.cfg2.lockPinSignalSelect); // RULE_14
		d.outs = {q.cfg0.powerdown, topo[3], topo[2], topo[1],
			q.cfg0.oscInputBufferPowerdown | q.cfg0.powerdown, // RULE_05
			q.cfg0.distributionSourceSelect & topo[0], // RULE_08
			q.refSelB, q.los, 2'b00};
		unique case (q.cfg2.lockPinIoType) // RULE_15
			PIN_PUSH_PULL:  d.outs[1:0] = {sig, 1'b1};
			PIN_OPEN_DRAIN: d.outs[1:0] = {1'b0, ~sig};
			default:        d.outs[1:0] = 2'b00; // pin is an input
		endcase
		d.fbSel     = topo[1] ? q.cfg0.feedbackSelect : 3'h0; // RULE_06
		d.freqRange = q.cfg0.oscInputFrequencyRange;
		// holdover pin follows its selector, same lag as the lock pin
		d.hoPin     = pinSig(q, q.cfg2.holdoverPinSignalSelect); // RULE_14
	end

	// single state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			q      <= '0;
			q.cfg1 <= CFG1_RESET;
			q.cfg2 <= CFG2_RESET;
		end else begin
			q <= d;
		end
	end
endmodule : jitter_cleaner_config_controls

// File: test/jcc_monitor.sv
// port-level assertion checker for the config bank
`timescale 1ns/1ps
module jcc_monitor (
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// bus handshakes
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic [31:0] rdata,
	// derived configuration levels
	input wire logic        deviceDown,
	input wire logic        pll1Active,
	input wire logic        pll2Active,
	input wire logic        zeroDelayActive,
	input wire logic        oscInputBufferDown,
	input wire logic [2:0]  feedbackSelect,
	input wire logic        distUsesDivider
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	// both halves of a write taken at one edge
	sequence wrTaken;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence readTaken;
		arvalid && arready;
	endsequence

	a_write_answer: assert property (wrTaken |-> ##[1:3] bvalid)
		else $error("write answer late");
	a_bvalid_holds: assert property (bvalid && !bready |=> bvalid)
		else $error("write answer dropped early");
	a_read_answer: assert property (readTaken |=> rvalid)
		else $error("read answer late");
	a_rdata_holds: assert property
		(rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read answer changed while waiting");
	a_powerdown_loops: assert property (deviceDown |->
		!pll1Active && !pll2Active && !zeroDelayActive)
		else $error("loop active in powerdown");
	a_powerdown_buffer: assert property (deviceDown |-> oscInputBufferDown)
		else $error("buffer up in powerdown");
	a_feedback_idle: assert property (!zeroDelayActive && !deviceDown
		|-> feedbackSelect == 3'h0)
		else $error("feedback select outside zero delay");
	a_divider_valid: assert property (distUsesDivider && !deviceDown
		|-> pll2Active)
		else $error("divider used without internal oscillator");
endmodule : jcc_monitor

bind jitter_cleaner_config_controls jcc_monitor mon (.clk, .rstn, .awvalid,
	.awready, .wvalid, .wready, .bvalid, .bready, .arvalid, .arready,
	.rvalid, .rready, .rdata, .deviceDown, .pll1Active, .pll2Active,
	.zeroDelayActive, .oscInputBufferDown, .feedbackSelect,
	.distUsesDivider);

// File: test/serial_host.sv
// host controller model driving the serial programming pins
`timescale 1ns/1ps
module serial_host (
	// serial pins
	output logic serClk,
	output logic serData,
	output logic serLatch
);
	initial begin
		serClk = 1'b0;
		serData = 1'b1;
		serLatch = 1'b0;
	end

	// msb first, clock idle between frames; n below 32 makes a short frame
	task automatic send(input logic [31:0] f, input int n);
		int i;
		#37;
		for (i = 31; i > 31 - n; i--) begin
			serData = f[i];
			#400 serClk = 1'b1;
			#400 serClk = 1'b0;
		end
		// no stale bit left on the line after the frame
		serData = ~serData;
		#400 serLatch = 1'b1;
		#800 serLatch = 1'b0;
	endtask : send
endmodule : serial_host

// File: test/jitter_cleaner_config_controls_tb.sv
// self-checking bench for the config bank
`timescale 1ns/1ps
`define CK(a, b) begin cmpCount++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module jitter_cleaner_config_controls_tb;
	import jcc_pkg::*;
	// stimulus and observed signals
	logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, referenceInputA = 0, lockIn = 0;
	logic referenceInputB = 0, pllLocked = 0, togA = 0, togB = 0;
	logic awready, wready, bvalid, arready, rvalid, serClk, serData;
	logic serLatch, deviceDown, pll1Active, pll2Active, zeroDelayActive;
	logic oscInputBufferDown, distUsesDivider, refSelectB, irq;
	logic lockStatusPinOut, lockStatusPinOe, holdoverPinOut;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, rdv;
	logic [1:0] bresp, rresp, rsp, oscInputFrequencyRange, signalLoss;
	logic [2:0] feedbackSelect;
	int fails = 0, cmpCount = 0, cyc = 0;

	jitter_cleaner_config_controls dut (.clk, .rstn, .awvalid, .awready,
		.awaddr, .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF),
		.bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
		.arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .serClk, .serData,
		.serLatch, .referenceInputA, .referenceInputB, .pllLocked,
		.deviceDown, .pll1Active, .pll2Active, .zeroDelayActive,
		.oscInputBufferDown, .feedbackSelect, .distUsesDivider,
		.oscInputFrequencyRange, .refSelectB, .signalLoss,
		.lockStatusPinIn(lockIn), .lockStatusPinOut, .lockStatusPinOe,
		.holdoverPinOut, .irq);
	serial_host host (.serClk, .serData, .serLatch);

	always #50 clk = ~clk;

	// hang guard and reference activity, one toggle per cycle
	always @(posedge clk) begin
		if (togA) referenceInputA <= ~referenceInputA;
		if (togB) referenceInputB <= ~referenceInputB;
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end

	function automatic logic [31:0] ad(input logic [4:0] i);
		return {25'h0, i, 2'h0};
	endfunction : ad

	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask : wt

	// handshakes sampled mid-cycle, so no race with the design's edge
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(negedge clk);
			ta = awready & awvalid;
			tw = wready & wvalid;
			tb = bvalid;
			rsp = bresp;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!tb);
		bready <= 1'b0;
	endtask : wr

	task automatic chkRd(input logic [31:0] a, input logic [31:0] e);
		logic ta, tr;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(negedge clk);
			ta = arready & arvalid;
			tr = rvalid;
			rdv = rdata;
			rsp = rresp;
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
		end while (!tr);
		rready <= 1'b0;
		`CK(rdv, e)
	endtask : chkRd

	task automatic tally_and_finish();
		$display("mismatches %0d of %0d compares", fails, cmpCount);
		if (fails == 0 && cmpCount > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		wt(2);
		chkRd(ad(IDX_CFG0), CFG0_RESET);
		chkRd(ad(IDX_CFG1), CFG1_RESET);
		chkRd(ad(IDX_CFG2), CFG2_RESET);
		chkRd(32'h20, 32'h0);
		`CK(rsp, RESP_SLVERR)
		wr(32'h20, 32'h1);
		`CK(rsp, RESP_SLVERR)
		// topology, feedback, frequency range, divider source
		wr(ad(IDX_CFG0), 32'h14C);
		wt(3);
		`CK({zeroDelayActive, feedbackSelect}, 4'hD)
		`CK({pll1Active, pll2Active}, 2'h1)
		wr(ad(IDX_CFG0), 32'h610);
		wt(3);
		`CK({oscInputFrequencyRange, feedbackSelect}, 5'h18)
		wr(ad(IDX_CFG0), 32'h810);
		wt(3);
		`CK(distUsesDivider, 1'b0)
		wr(ad(IDX_CFG0), 32'h800);
		wt(3);
		`CK(distUsesDivider, 1'b1)
		`CK({pll1Active, pll2Active, zeroDelayActive}, 3'h6)
		wr(ad(IDX_CFG0), 32'h22);
		wt(3);
		`CK({deviceDown, oscInputBufferDown, pll1Active}, 3'h6)
		wr(ad(IDX_CFG0), 32'h20);
		wt(3);
		`CK({deviceDown, oscInputBufferDown}, 2'h1)
		// software reset, repeated while the bit stays set
		wr(ad(IDX_CFG2), 32'h12);
		wr(ad(IDX_CFG0), 32'h1);
		chkRd(ad(IDX_CFG2), CFG2_RESET);
		chkRd(ad(IDX_CFG0), 32'h1);
		wr(ad(IDX_CFG2), 32'h12);
		wr(ad(IDX_CFG0), 32'h1);
		chkRd(ad(IDX_CFG2), CFG2_RESET);
		wr(ad(IDX_CFG0), 32'h0);
		wr(ad(IDX_CFG2), 32'h12);
		chkRd(ad(IDX_CFG2), 32'h12);
		// lock refuses bus and serial writes and raises the event
		wr(ad(IDX_LOCK), 32'h1);
		wr(ad(IDX_CFG1), 32'h0B);
		`CK(rsp, RESP_OKAY)
		host.send({27'h0B, IDX_CFG1}, 32);
		chkRd(ad(IDX_CFG1), CFG1_RESET);
		chkRd(ad(IDX_IRQ_STAT), 32'h8);
		wr(ad(IDX_IRQ_EN), 32'h8);
		wt(2);
		`CK(irq, 1'b1)
		wr(ad(IDX_IRQ_CLR), 32'h8);
		wt(2);
		`CK(irq, 1'b0)
		wr(ad(IDX_LOCK), 32'h0);
		host.send({27'h0B, IDX_CFG1}, 32);
		chkRd(ad(IDX_CFG1), 32'h0B);
		host.send({27'h03, IDX_CFG1}, 31);
		chkRd(ad(IDX_CFG1), 32'h0B);
		// signal loss with a two-step timeout
		togA <= 1'b1;
		togB <= 1'b1;
		wr(ad(IDX_CFG1), 32'h3C);
		wt(40);
		`CK(signalLoss, 2'h0)
		togB <= 1'b0;
		wt(20);
		`CK(signalLoss, 2'h0)
		wt(30);
		`CK(signalLoss, 2'h2)
		wr(ad(IDX_CFG1), 32'h3E);
		wt(4);
		`CK(refSelectB, 1'b0)
		togA <= 1'b0;
		togB <= 1'b1;
		wt(60);
		`CK(refSelectB, 1'b1)
		wr(ad(IDX_CFG1), 32'h3A);
		togA <= 1'b1;
		togB <= 1'b0;
		wt(60);
		`CK(refSelectB, 1'b1)
		wr(ad(IDX_CFG1), 32'h20);
		wt(4);
		`CK(refSelectB, 1'b0)
		wr(ad(IDX_CFG1), 32'h04);
		wt(4);
		`CK(signalLoss, 2'h0)
		// both losses and both switches since the last clear
		chkRd(ad(IDX_IRQ_STAT), 32'h7);
		// status pin selection and direction
		pllLocked <= 1'b1;
		lockIn <= 1'b1;
		wr(ad(IDX_CFG2), 32'h2E);
		wt(3);
		`CK({lockStatusPinOut, lockStatusPinOe, holdoverPinOut}, 3'h7)
		wr(ad(IDX_CFG2), 32'h06);
		wt(3);
		`CK({lockStatusPinOe, holdoverPinOut}, 2'h0)
		chkRd(ad(IDX_STATUS), 32'h8);
		// open drain: drives low only while the selected signal is low
		wr(ad(IDX_CFG2), 32'h12);
		wt(3);
		`CK({lockStatusPinOut, lockStatusPinOe}, 2'h1)
		wr(ad(IDX_CFG2), 32'h16);
		wt(3);
		`CK({lockStatusPinOut, lockStatusPinOe}, 2'h0)
		tally_and_finish();
	end
endmodule : jitter_cleaner_config_controls_tb
